// ===== dv/epm_power_mgr_assertions.sv
// checker: port-level assertions for the energy-mode power manager
`timescale 1ns/100ps
`default_nettype none
module epm_power_mgr_assertions
(
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire logic                  busy,
  input wire epm_pkg::epm_mode_t    mode_q,
  input wire epm_pkg::epm_domains_t domain_pwr_q,
  input wire epm_pkg::epm_scale_t   reg_scale_q,
  input wire logic                  clk_limit_q,
  input wire logic                  clk_release_q,
  input wire logic                  iso_release_q,
  input wire logic [2:0]            aux_periph_en,
  input wire epm_pkg::epm_rst_src_t rst_req,
  input wire logic                  sys_rst_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // flat view: always-on, base, aux 1..3, shared, active
  wire logic [6:0] dom;
  assign dom = domain_pwr_q;
  ////////////////////////////////////////////////////////////////////////////
  // domain map; the shutoff, aux and active-off checks are judged once the sequencer has been quiet a few cycles
  always_on_a: assert property (dom[6])
    else $error("always-on domain off");
  shutoff_dark_a: assert property ((!busy)[*3] ##0 mode_q == 3'h4 |-> dom[5:0] == 6'h0)
    else $error("low-power group on in shutoff");
  base_on_a: assert property (mode_q != 3'h4 |-> dom[5])
    else $error("base domain off");
  aux_demand_a: assert property ((!busy && $stable(aux_periph_en))[*4] ##0 mode_q inside {3'h2, 3'h3}
    |-> (|dom[4:2]) == (|aux_periph_en))
    else $error("aux domain not following demand");
  shared_aux_a: assert property (|dom[4:2] |-> dom[1])
    else $error("shared aux off beside aux");
  active_on_a: assert property (mode_q inside {3'h0, 3'h1} |-> dom[0])
    else $error("active domain off in run modes");
  active_off_a: assert property ((!busy)[*3] ##0 mode_q >= 3'h2 |-> !dom[0])
    else $error("active domain on in low modes");
  ////////////////////////////////////////////////////////////////////////////
  // regulator, sequencing and reset stretch
  clk_limit_a: assert property ($stable(reg_scale_q)[*2] |-> clk_limit_q == (reg_scale_q != 2'h2))
    else $error("clock limit wrong for scale");
  seq_bound_a: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("mode change took too long");
  hold_release_a: assert property (busy && $past(busy) |-> !clk_release_q && !iso_release_q)
    else $error("release during sequence");
  release_power_a: assert property (clk_release_q || iso_release_q |-> dom[0])
    else $error("release with active domain off");
  rst_stretch_a: assert property (|rst_req |-> ##2 (!sys_rst_n)[*8])
    else $error("system reset not stretched");
endmodule // epm_power_mgr_assertions

bind epm_power_mgr epm_power_mgr_assertions i_chk
(
  .ref_clk       (ref_clk),
  .nrst          (nrst),
  .busy          (busy),
  .mode_q        (mode_q),
  .domain_pwr_q  (domain_pwr_q),
  .reg_scale_q   (reg_scale_q),
  .clk_limit_q   (clk_limit_q),
  .clk_release_q (clk_release_q),
  .iso_release_q (iso_release_q),
  .aux_periph_en (aux_periph_en),
  .rst_req       (rst_req),
  .sys_rst_n     (sys_rst_n)
);
`default_nettype wire

// ===== dv/tb_top.sv
// testbench: self-checking bench for the energy-mode power manager
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // one row: scale write, mode, demand, expected domains and scale
  typedef struct packed {
    logic [7:0] scale;
    logic [2:0] mode;
    logic [2:0] aux;
    logic       shr;
    logic [6:0] dom;
    logic [2:0] exp_scale; // bit2 set: scale not judged
  } epm_row_t;
  logic                  ref_clk;
  logic                  nrst;
  logic [3:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_rdata;
  logic                  mode_req;
  epm_pkg::epm_mode_t    mode_req_sel;
  logic [2:0]            aux_periph_en;
  logic                  shared_periph_en;
  logic                  supply_low;
  epm_pkg::epm_rst_src_t rst_req;
  epm_pkg::epm_domains_t domain_pwr_q;
  epm_pkg::epm_scale_t   reg_scale_q;
  logic                  clk_limit_q;
  logic                  clk_release_q;
  logic                  iso_release_q;
  logic [7:0]            ram_pwr_q;
  logic                  supply_irq;
  logic                  sys_rst_n;
  epm_pkg::epm_mode_t    mode_q;
  logic                  busy;
  int                    err_count;
  int                    n_checks;
  epm_row_t              rows [7];
  ////////////////////////////////////////////////////////////////////////////
  epm_power_mgr #(.RAM_BLOCKS(8)) i_epm_power_mgr
  (
    .ref_clk          (ref_clk),
    .nrst             (nrst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .mode_req         (mode_req),
    .mode_req_sel     (mode_req_sel),
    .aux_periph_en    (aux_periph_en),
    .shared_periph_en (shared_periph_en),
    .supply_low       (supply_low),
    .rst_req          (rst_req),
    .domain_pwr_q     (domain_pwr_q),
    .reg_scale_q      (reg_scale_q),
    .clk_limit_q      (clk_limit_q),
    .clk_release_q    (clk_release_q),
    .iso_release_q    (iso_release_q),
    .ram_pwr_q        (ram_pwr_q),
    .supply_irq       (supply_irq),
    .sys_rst_n        (sys_rst_n),
    .mode_q           (mode_q),
    .busy             (busy)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic go(input logic [2:0] m);
    @(posedge ref_clk);
    mode_req     <= 1'b1;
    mode_req_sel <= epm_pkg::epm_mode_t'(m);
    @(posedge ref_clk);
    mode_req <= 1'b0;
  endtask
  // bounded wait for the sequencer, then let late domain drops land
  task automatic settle;
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (busy !== 1'b0 && n < 80)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 80) err_count++;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // free-running 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // watchdog: whole run is a few hundred cycles
  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    {nrst, reg_wr, reg_rd, mode_req, supply_low, shared_periph_en} = '0;
    {reg_addr, reg_wdata, aux_periph_en} = '0;
    mode_req_sel = epm_pkg::EPM_ACTIVE_MODE;
    rst_req = '0;
    err_count = 0;
    n_checks = 0;
    rows[0] = '{8'h02, 3'h2, 3'h0, 1'b0, 7'h60, 3'h0};
    rows[1] = '{8'h02, 3'h3, 3'h7, 1'b0, 7'h7e, 3'h0};
    rows[2] = '{8'h12, 3'h2, 3'h0, 1'b1, 7'h62, 3'h1};
    rows[3] = '{8'h01, 3'h1, 3'h0, 1'b0, 7'h7f, 3'h1};
    rows[4] = '{8'h02, 3'h0, 3'h0, 1'b0, 7'h7f, 3'h2};
    rows[5] = '{8'h02, 3'h4, 3'h0, 1'b0, 7'h40, 3'h4};
    rows[6] = '{8'h02, 3'h0, 3'h0, 1'b0, 7'h7f, 3'h2};
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1 chk(domain_pwr_q, 7'h7f);
    chk(reg_scale_q, 2'h2);
    chk(mode_q, 3'h0);
    chk(ram_pwr_q, 8'hff);
    chk(sys_rst_n, 1'b0);
    rd(epm_pkg::EPM_REG_SCALE, 32'h2);
    rd(4'hf, 32'h0);
    repeat (20) @(posedge ref_clk);
    #1 chk(sys_rst_n, 1'b1);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      aux_periph_en    <= rows[i].aux;
      shared_periph_en <= rows[i].shr;
      wr(epm_pkg::EPM_REG_SCALE, 32'(rows[i].scale));
      go(rows[i].mode);
      settle();
      chk(domain_pwr_q, rows[i].dom);
      chk(mode_q, rows[i].mode);
      chk(clk_release_q, rows[i].mode == 3'h0);
      chk(iso_release_q, rows[i].dom[0]);
      if (!rows[i].exp_scale[2]) chk(reg_scale_q, rows[i].exp_scale[1:0]);
      if (!rows[i].exp_scale[2]) chk(clk_limit_q, rows[i].exp_scale != 3'h2);
    end
    $display("mode table done");
    wr(epm_pkg::EPM_REG_SCALE, 32'h33); // reserved codes, both refused
    rd(epm_pkg::EPM_REG_SCALE, 32'h02);
    go(3'h2);
    wr(epm_pkg::EPM_REG_MODE, 32'h3); // lands while busy, so ignored
    settle();
    chk(mode_q, 3'h2);
    wr(epm_pkg::EPM_REG_MODE, 32'h0);
    settle();
    rd(epm_pkg::EPM_REG_MODE, 32'h0);
    wr(epm_pkg::EPM_REG_MODE, 32'h5); // illegal code, refused
    rd(epm_pkg::EPM_REG_MODE, 32'h0);
    chk(domain_pwr_q, 7'h7f);
    rd(epm_pkg::EPM_REG_STATUS, 32'h08);
    rd(epm_pkg::EPM_REG_DOMAINS, 32'h7f);
    $display("mode refusal test done");
    wr(epm_pkg::EPM_REG_RAM_OFF, 32'h05);
    repeat (2) @(posedge ref_clk);
    #1 chk(ram_pwr_q, 8'hfa);
    wr(epm_pkg::EPM_REG_SUPPLY, 32'h2);
    @(posedge ref_clk);
    supply_low <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(supply_irq, 1'b1);
    wr(epm_pkg::EPM_REG_SUPPLY, 32'h3); // clear flag, keep mask
    repeat (2) @(posedge ref_clk);
    #1 chk(supply_irq, 1'b0);
    rd(epm_pkg::EPM_REG_SUPPLY, 32'h6);
    @(posedge ref_clk);
    supply_low <= 1'b0;
    $display("ram and supply test done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk);
      rst_req <= epm_pkg::epm_rst_src_t'(5'h1 << i);
      @(posedge ref_clk);
      rst_req <= '0;
      #1 chk(sys_rst_n, 1'b0);
      repeat (20) @(posedge ref_clk);
      #1 chk(sys_rst_n, 1'b1);
      rd(epm_pkg::EPM_REG_RST_CAUSE, 32'h1 << i);
      wr(epm_pkg::EPM_REG_RST_CAUSE, 32'h0);
    end
    $display("reset source test done");
    // reset in the middle of a power-up phase
    go(3'h2);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1 chk(domain_pwr_q, 7'h7f);
    chk(busy, 1'b0);
    chk(mode_q, 3'h0);
    chk(reg_scale_q, 2'h2);
    chk(sys_rst_n, 1'b0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

// ===== src/epm_domain_map.sv
// module: combinational map from energy mode to domain power enables
`timescale 1ns/100ps
`default_nettype none
module epm_domain_map
(
  input  wire epm_pkg::epm_mode_t mode,
  input  wire logic [2:0]         aux_periph_en,
  input  wire logic               shared_periph_en,
  output epm_pkg::epm_domains_t   domains
);

  logic low_pw;
  logic run;
  logic shut;

  //////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign run    = (mode == epm_pkg::EPM_ACTIVE_MODE) || (mode == epm_pkg::EPM_SLEEP_MODE);
  assign low_pw = (mode == epm_pkg::EPM_DEEP_SLEEP_MODE) || (mode == epm_pkg::EPM_STOP_MODE);
  assign shut   = (mode == epm_pkg::EPM_SHUTOFF_MODE);

  // aux domains run freely in run modes, on demand in deep/stop
  always_comb
  begin
    domains.always_on_domain      = 1'b1;
    domains.base_low_power_domain = !shut;
    domains.first_aux_domain      = run || (low_pw && aux_periph_en[0]);
    domains.second_aux_domain     = run || (low_pw && aux_periph_en[1]);
    domains.third_aux_domain      = run || (low_pw && aux_periph_en[2]);
    domains.shared_aux_domain     = run || (low_pw && (shared_periph_en || (|aux_periph_en)));
    // active domain on in run modes
    domains.active_domain         = run;
    if (shut)
    begin
      domains.first_aux_domain  = 1'b0;
      domains.second_aux_domain = 1'b0;
      domains.third_aux_domain  = 1'b0;
      domains.shared_aux_domain = 1'b0;
    end
  end

endmodule // epm_domain_map
`default_nettype wire

// ===== src/epm_pkg.sv
// package: constants and types of the energy-mode power domain manager
// Behaviour
// - always-on domain powered in every mode
// - shutoff mode powers down whole low-power group
// - base low-power domain on active through stop
// - aux domain on in deep/stop if peripheral enabled
// - any aux on forces shared aux on
// - active domain on in active and sleep
// - active domain off in deep, stop, shutoff
// - two scaling selections: run pair, low pair
// - run scaling selection resets to full speed
// - intermediate level caps core clock at limit
// - lowest level selectable for deep and stop
// - mode change retargets regulator automatically
// - unused RAM blocks switch off individually
// - low supply raises supply-monitor interrupt
// - reset manager collects all reset sources
package epm_pkg;

  typedef enum logic [2:0] {
    EPM_ACTIVE_MODE     = 3'h0,
    EPM_SLEEP_MODE      = 3'h1,
    EPM_DEEP_SLEEP_MODE = 3'h2,
    EPM_STOP_MODE       = 3'h3,
    EPM_SHUTOFF_MODE    = 3'h4
  } epm_mode_t;

  typedef enum logic [1:0] {
    EPM_LOWEST_SCALING_LEVEL       = 2'h0,
    EPM_INTERMEDIATE_SCALING_LEVEL = 2'h1,
    EPM_FULL_SPEED_SCALING_LEVEL   = 2'h2
  } epm_scale_t;

  // sequencer states, gray along the usual path
  typedef enum logic [1:0] {
    EPM_ST_STEADY  = 2'b00,
    EPM_ST_POWER   = 2'b01,
    EPM_ST_SCALE   = 2'b11,
    EPM_ST_RELEASE = 2'b10
  } epm_state_t;

  // domain power enables
  typedef struct packed {
    logic always_on_domain;
    logic base_low_power_domain;
    logic first_aux_domain;
    logic second_aux_domain;
    logic third_aux_domain;
    logic shared_aux_domain;
    logic active_domain;
  } epm_domains_t;

  // reset request sources
  typedef struct packed {
    logic supply_monitor;
    logic pin;
    logic software;
    logic lockup;
    logic watchdog;
  } epm_rst_src_t;

  // register offsets
  localparam logic [3:0] EPM_REG_MODE     = 4'h0;
  localparam logic [3:0] EPM_REG_SCALE    = 4'h1;
  localparam logic [3:0] EPM_REG_RAM_OFF  = 4'h2;
  localparam logic [3:0] EPM_REG_STATUS   = 4'h3;
  localparam logic [3:0] EPM_REG_DOMAINS  = 4'h4;
  localparam logic [3:0] EPM_REG_RST_CAUSE = 4'h5;
  localparam logic [3:0] EPM_REG_SUPPLY   = 4'h6;

  // field positions in scale register
  localparam int EPM_SCALE_RUN_LSB = 0;
  localparam int EPM_SCALE_LOW_LSB = 4;

  // reset values
  localparam epm_scale_t EPM_RUN_SCALE_RST = EPM_FULL_SPEED_SCALING_LEVEL;
  localparam epm_scale_t EPM_LOW_SCALE_RST = EPM_LOWEST_SCALING_LEVEL;

  // intermediate level core clock limit
  localparam int EPM_INTERMEDIATE_CLK_LIMIT_MHZ = 40;

  // timing: domain power-up and regulator settling
  localparam int   EPM_REF_CLK_MHZ     = 50;
  localparam int   EPM_POWER_UP_NS     = 200;
  localparam int   EPM_SCALE_SETTLE_NS = 400;
  localparam logic [7:0] EPM_POWER_UP_CYC =
    8'((EPM_POWER_UP_NS * EPM_REF_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] EPM_SCALE_SETTLE_CYC =
    8'((EPM_SCALE_SETTLE_NS * EPM_REF_CLK_MHZ + 999) / 1000);

  // reset pulse length from reset manager
  localparam logic [7:0] EPM_RST_PULSE_CYC = 8'h10;

endpackage

// ===== src/epm_power_mgr.sv
// module: energy-mode power domain manager top
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module epm_power_mgr
#(
  parameter int RAM_BLOCKS = 8
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire logic                  mode_req,
  input  wire epm_pkg::epm_mode_t    mode_req_sel,
  input  wire logic [2:0]            aux_periph_en,
  input  wire logic                  shared_periph_en,
  input  wire logic                  supply_low,
  input  wire epm_pkg::epm_rst_src_t rst_req,
  output epm_pkg::epm_domains_t      domain_pwr_q,
  output epm_pkg::epm_scale_t        reg_scale_q,
  output logic                       clk_limit_q,
  output logic                       clk_release_q,
  output logic                       iso_release_q,
  output logic [RAM_BLOCKS-1:0]      ram_pwr_q,
  output logic                       supply_irq,
  output logic                       sys_rst_n,
  output epm_pkg::epm_mode_t         mode_q,
  output logic                       busy
);

  // wait_q serves both sequencer phases; 8 bits hold the longest count
  epm_pkg::epm_state_t   state_q;
  epm_pkg::epm_mode_t    tgt_mode_q;
  epm_pkg::epm_scale_t   run_scale_q;
  epm_pkg::epm_scale_t   low_scale_q;
  epm_pkg::epm_scale_t   tgt_scale;
  epm_pkg::epm_domains_t tgt_domains;
  epm_pkg::epm_rst_src_t cause;
  logic [RAM_BLOCKS-1:0] ram_off_q;
  logic [7:0]            wait_q;
  logic                  supply_flag_q;
  logic                  supply_mask_q;
  logic                  supply_low_q;
  logic                  cause_clr;
  logic                  tgt_run;
  logic                  start;

  //////////////////////////////////////////////////////////////////////////////
  // submodules
  // the map always reads the destination mode, so domains follow it
  epm_domain_map u_map
  (
    .mode             (tgt_mode_q),
    .aux_periph_en    (aux_periph_en),
    .shared_periph_en (shared_periph_en),
    .domains          (tgt_domains)
  );

  epm_reset_mgr u_rst
  (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .rst_req   (rst_req),
    .cause_clr (cause_clr),
    .sys_rst_n (sys_rst_n),
    .cause_q   (cause)
  );

  //////////////////////////////////////////////////////////////////////////////
  // target scaling for the destination mode
  assign tgt_run = (tgt_mode_q == epm_pkg::EPM_ACTIVE_MODE) || (tgt_mode_q == epm_pkg::EPM_SLEEP_MODE);
  // run pair vs low pair selection
  assign tgt_scale = tgt_run ? run_scale_q : low_scale_q;
  // a hardware request wins over a register write in the same cycle
  assign start     = mode_req && (state_q == epm_pkg::EPM_ST_STEADY) && (mode_req_sel != mode_q)
                     && (mode_req_sel <= epm_pkg::EPM_SHUTOFF_MODE);
  assign busy      = (state_q != epm_pkg::EPM_ST_STEADY);
  assign cause_clr = reg_wr && (reg_addr == epm_pkg::EPM_REG_RST_CAUSE);

  //////////////////////////////////////////////////////////////////////////////
  // scaling selections written by software
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      run_scale_q <= epm_pkg::EPM_RUN_SCALE_RST;
      low_scale_q <= epm_pkg::EPM_LOW_SCALE_RST;
    end
    else if (reg_wr && (reg_addr == epm_pkg::EPM_REG_SCALE))
    begin
      // lowest level is not allowed for run modes, keep old
      if (reg_wdata[epm_pkg::EPM_SCALE_RUN_LSB +: 2] inside {2'h1, 2'h2})
        run_scale_q <= epm_pkg::epm_scale_t'(reg_wdata[epm_pkg::EPM_SCALE_RUN_LSB +: 2]);
      // low pair may take lowest level
      if (reg_wdata[epm_pkg::EPM_SCALE_LOW_LSB +: 2] != 2'h3)
        low_scale_q <= epm_pkg::epm_scale_t'(reg_wdata[epm_pkg::EPM_SCALE_LOW_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      ram_off_q <= '0;
    else if (reg_wr && (reg_addr == epm_pkg::EPM_REG_RAM_OFF))
      ram_off_q <= reg_wdata[RAM_BLOCKS-1:0];
  end

  // ram blocks follow their off bits only while the base domain is up
  // a block loses power with the base domain whatever its off bit says
  genvar gi;
  generate
    for (gi = 0; gi < RAM_BLOCKS; gi++)
    begin : g_ram
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
          ram_pwr_q[gi] <= 1'b1;
        else
          ram_pwr_q[gi] <= !ram_off_q[gi] && domain_pwr_q.base_low_power_domain;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // supply monitor flag, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      supply_low_q  <= 1'b0;
      supply_flag_q <= 1'b0;
      supply_mask_q <= 1'b0;
    end
    else
    begin
      // delayed copy is both the status bit and the edge detector
      supply_low_q <= supply_low;
      if (supply_low && !supply_low_q)
        supply_flag_q <= 1'b1;
      else if (reg_wr && (reg_addr == epm_pkg::EPM_REG_SUPPLY) && reg_wdata[0])
        supply_flag_q <= 1'b0;
      if (reg_wr && (reg_addr == epm_pkg::EPM_REG_SUPPLY))
        supply_mask_q <= reg_wdata[1];
    end
  end

  assign supply_irq = supply_flag_q && supply_mask_q;

  //////////////////////////////////////////////////////////////////////////////
  // mode sequencer: power up, settle regulator, then release
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q    <= epm_pkg::EPM_ST_STEADY;
      tgt_mode_q <= epm_pkg::EPM_ACTIVE_MODE;
      mode_q     <= epm_pkg::EPM_ACTIVE_MODE;
      wait_q     <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        epm_pkg::EPM_ST_STEADY:
        begin
          if (start)
          begin
            tgt_mode_q <= mode_req_sel;
            state_q    <= epm_pkg::EPM_ST_POWER;
            wait_q     <= epm_pkg::EPM_POWER_UP_CYC;
          end
          else if (reg_wr && (reg_addr == epm_pkg::EPM_REG_MODE))
          begin
            // an illegal or unchanged code must not reach the domain map, which
            // is tracked while steady and would drop domains at once
            if ((reg_wdata[2:0] != mode_q) && (reg_wdata[2:0] <= 3'h4))
            begin
              tgt_mode_q <= epm_pkg::epm_mode_t'(reg_wdata[2:0]);
              state_q    <= epm_pkg::EPM_ST_POWER;
              wait_q     <= epm_pkg::EPM_POWER_UP_CYC;
            end
          end
        end
        epm_pkg::EPM_ST_POWER:
        begin
          if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
          else
          begin
            state_q <= epm_pkg::EPM_ST_SCALE;
            wait_q  <= epm_pkg::EPM_SCALE_SETTLE_CYC;
          end
        end
        epm_pkg::EPM_ST_SCALE:
        begin
          if (wait_q != 8'h00)
            wait_q <= wait_q - 8'h01;
          else
            state_q <= epm_pkg::EPM_ST_RELEASE;
        end
        epm_pkg::EPM_ST_RELEASE:
        begin
          // destination settled: it becomes the current mode
          mode_q  <= tgt_mode_q;
          state_q <= epm_pkg::EPM_ST_STEADY;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // domain power: turn on early, turn off only after release
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      domain_pwr_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    else if (state_q == epm_pkg::EPM_ST_STEADY)
      // track peripheral enables in steady state
      domain_pwr_q <= tgt_domains;
    else if (state_q == epm_pkg::EPM_ST_POWER)
      // active domain off only at release
      domain_pwr_q <= domain_pwr_q | tgt_domains;
    else if (state_q == epm_pkg::EPM_ST_RELEASE)
      domain_pwr_q <= tgt_domains;
  end

  // regulator retargets during sequence
  // steady: follow the current mode's selection, so a rewrite applies at once
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      reg_scale_q <= epm_pkg::EPM_RUN_SCALE_RST;
    else if (state_q == epm_pkg::EPM_ST_SCALE || state_q == epm_pkg::EPM_ST_STEADY)
      reg_scale_q <= (state_q == epm_pkg::EPM_ST_SCALE) ? tgt_scale
                     : ((mode_q == epm_pkg::EPM_ACTIVE_MODE || mode_q == epm_pkg::EPM_SLEEP_MODE)
                        ? run_scale_q : low_scale_q);
  end

  // below full speed, clock limit asserted
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      clk_limit_q <= 1'b0;
    else
      // lags the regulator a cycle; software must already have slowed the core
      clk_limit_q <= (reg_scale_q != epm_pkg::EPM_FULL_SPEED_SCALING_LEVEL);
  end

  // clocks and isolation follow settled mode
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      clk_release_q <= 1'b1;
      iso_release_q <= 1'b1;
    end
    else if (state_q != epm_pkg::EPM_ST_STEADY)
    begin
      clk_release_q <= 1'b0;
      iso_release_q <= 1'b0;
    end
    else
    begin
      clk_release_q <= (mode_q == epm_pkg::EPM_ACTIVE_MODE);
      iso_release_q <= domain_pwr_q.active_domain;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read, data one cycle after strobe
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        epm_pkg::EPM_REG_MODE:      reg_rdata <= {29'h0, mode_q};
        epm_pkg::EPM_REG_SCALE:     reg_rdata <= {26'h0, low_scale_q, 2'h0, run_scale_q};
        epm_pkg::EPM_REG_RAM_OFF:   reg_rdata <= 32'(ram_off_q);
        // bit 1 is a spare, kept zero
        epm_pkg::EPM_REG_STATUS:    reg_rdata <= {27'h0, clk_limit_q, reg_scale_q, 1'b0, busy};
        epm_pkg::EPM_REG_DOMAINS:   reg_rdata <= {25'h0, domain_pwr_q};
        epm_pkg::EPM_REG_RST_CAUSE: reg_rdata <= {27'h0, cause};
        epm_pkg::EPM_REG_SUPPLY:    reg_rdata <= {29'h0, supply_low_q, supply_mask_q, supply_flag_q};
        default:                    reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // epm_power_mgr
`default_nettype wire

// ===== src/epm_reset_mgr.sv
// module: reset manager, gathers reset sources into a system reset
`timescale 1ns/100ps
`default_nettype none
module epm_reset_mgr
(
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire epm_pkg::epm_rst_src_t rst_req,
  input  wire logic                  cause_clr,
  output logic                       sys_rst_n,
  output epm_pkg::epm_rst_src_t      cause_q
);

  logic [7:0] cnt_q;

  //////////////////////////////////////////////////////////////////////////////
  // any source stretches reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      cnt_q <= epm_pkg::EPM_RST_PULSE_CYC;
    else if (|rst_req)
      cnt_q <= epm_pkg::EPM_RST_PULSE_CYC;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      cause_q <= '0;
    else
      cause_q <= (cause_clr ? '0 : cause_q) | rst_req;
  end

  assign sys_rst_n = (cnt_q == 8'h00); // held low while stretching

endmodule // epm_reset_mgr
`default_nettype wire
